// ---- rtl/fieldbus_setup_params.svh ----
/*
  Constants of the fieldbus master setup decoder: register offsets, field
  positions, host word map and timing figures.
  Assumes inclusion by the package only, once per compile unit.
*/
`ifndef FIELDBUS_SETUP_PARAMS_SVH
`define FIELDBUS_SETUP_PARAMS_SVH

// Register byte offsets
`define OFS_CONFIG      8'h00
`define OFS_IO_BASE     8'h04
`define OFS_PARAM_BASE  8'h08
`define OFS_BAUD        8'h0c
`define OFS_CYCLE       8'h10
`define OFS_STATUS      8'h14
`define OFS_CONTROL     8'h18
`define OFS_IRQ_STAT    8'h1c
`define OFS_IRQ_MASK    8'h20
`define OFS_REG_TABLE   8'h24
`define OFS_PRESENT     8'h28
`define OFS_LOOKUP      8'h2c

// Unit number and host word map
`define UNIT_MAX_NARROW 7'h5f
`define UNIT_MAX_WIDE   7'h5e
`define DIGIT_MAX       4'h9
`define IO_BASE_WORD    16'h07d0
`define IO_UNIT_STRIDE  16'h000a
`define PARAM_BASE_WORD 16'h4e20
`define PARAM_STRIDE    16'h0064
`define PARAM_SIZE      16'h0064
`define DATA_WORDS_NAR  8'h04
`define DATA_WORDS_WIDE 8'h08
`define STAT_WORDS_NAR  8'h02
`define STAT_WORDS_WIDE 8'h04
`define TOTAL_WORDS_NAR 8'h0a
`define TOTAL_WORDS_WID 8'h14

// Communication rates in bits per second, cycle times in nanoseconds
`define BAUD_FAST_BPS   20'hb71b0
`define BAUD_LONG_BPS   20'h16e36
`define CYC_FAST_NAR_NS 500000
`define CYC_FAST_WID_NS 800000
`define CYC_LONG_NAR_NS 4000000
`define CYC_LONG_WID_NS 6000000
`define CLK_PERIOD_NS   25

// Interrupt status bit positions
`define IRQ_LINK_OK_LAMP_ERR    0
`define IRQ_HALT        1
`define IRQ_DUP_UNIT    2
`define IRQ_BAD_SETTING 3
`define IRQ_UNREG_JOIN  4
`define IRQ_REG_JOIN    5
`define IRQ_BITS        6

`endif

// ---- rtl/fieldbus_setup_pkg.sv ----
/*
  Types of the fieldbus master setup decoder: state codes and the state record.
  Assumes the constants header sits beside it on the include path.
*/
package fieldbus_setup_pkg;
  `include "fieldbus_setup_params.svh"

  typedef enum logic [4:0] {
    ST_LOAD  = 5'h01,
    ST_CHECK = 5'h02,
    ST_RUN   = 5'h04,
    ST_HALT  = 5'h08,
    ST_FAULT = 5'h10
  } run_state_t;

  typedef struct packed {
    run_state_t            state;
    logic [6:0]            unit;
    logic                  node_wide;
    logic                  rate_long;
    logic                  stop_mode;
    logic                  regs_en;
    logic                  dup_fault;
    logic                  bad_setting;
    logic [22:0]           cyc_cnt;
    logic                  cycle_strobe;
    logic                  exchange_en;
    logic                  link_ok;
    logic [`IRQ_BITS-1:0]  irq_stat;
    logic [`IRQ_BITS-1:0]  irq_mask;
    logic                  irq;
    logic [31:0]           reg_table;
    logic [31:0]           present;
    logic [4:0]            lookup;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
  } setup_state_t;
endpackage : fieldbus_setup_pkg

// ---- rtl/fieldbus_master_setup_decode.sv ----
/*
  Setup and address-allocation logic of a fieldbus master unit: switch
  capture, host word window, parameter block, rate and cycle timing,
  stop-on-error handling, slave registration check and an APB register file.
  Assumes switch and presence inputs synchronous to pclk and a host that
  reports which unit numbers other units already claim.
*/
`timescale 1ns/1ps

// Functional notes
// - The unit number is read as two decimal digits, valid 0..95 narrow or 0..94 wide.
// - Narrow range serves nodes 0-7 each way and takes 10 words: 4 out, 4 in, 2 status.
// - Wide range serves nodes 0-15 each way and takes 20 words: 8 out, 8 in, 4 status.
// - Wide range claims its own and the next unit number, which no other unit may hold.
// - A duplicated unit number raises a duplicate fault and the system does not start.
// - The first host word is 2000 plus ten times the unit number.
// - The parameter block is 100 words starting at 20000 plus 100 times the unit number.
// - Rate switch off gives 750 kbps for 100 m, on gives 93.75 kbps for 500 m.
// - Cycle time is 0.5/0.8 ms at high speed and 4.0/6.0 ms long distance, narrow/wide.
// - Stop mode off keeps exchanging after a link_ok_lamp error; on halts the exchange.
// - After a halt the unit stays halted until a power cycle or a unit restart.
// - With registration on, present slaves are checked against the registration tables.
// - Input and output node numbers are separate spaces.
// - After reset all mode switches read off and the unit number reads 00.
// - Output words come first, then input words, two slaves a word, even slave low byte.
module fieldbus_master_setup_decode
  import fieldbus_setup_pkg::*;
#(
  parameter int CYC_FAST_NAR = `CYC_FAST_NAR_NS / `CLK_PERIOD_NS,
  parameter int CYC_FAST_WID = `CYC_FAST_WID_NS / `CLK_PERIOD_NS,
  parameter int CYC_LONG_NAR = `CYC_LONG_NAR_NS / `CLK_PERIOD_NS,
  parameter int CYC_LONG_WID = `CYC_LONG_WID_NS / `CLK_PERIOD_NS
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [3:0]  unit_tens_sw,
  input  wire logic [3:0]  unit_ones_sw,
  input  wire logic        node_range_sw,
  input  wire logic        bus_rate_select,
  input  wire logic        stop_on_error_sw,
  input  wire logic        registration_sw,
  input  wire logic [95:0] host_unit_claimed,
  input  wire logic        link_ok_lamp_error,
  input  wire logic [15:0] slave_in_present,
  input  wire logic [15:0] slave_out_present,
  output logic             exchange_enable,
  output logic             cycle_strobe,
  output logic             link_ok_lamp,
  output logic             irq
);

  setup_state_t st_reg;
  setup_state_t st_next;

  // Combinational helpers
  logic [6:0]            unit_raw;
  logic                  unit_bad;
  logic                  claim_hit;
  logic [15:0]           first_word;
  logic [15:0]           param_word;
  logic [7:0]            data_words;
  logic [7:0]            stat_words;
  logic [7:0]            total_words;
  logic [19:0]           baud_bps;
  logic [22:0]           cyc_len;
  logic [15:0]           node_mask;
  logic [31:0]           present_now;
  logic [31:0]           joined;
  logic [`IRQ_BITS-1:0]  irq_event;
  logic [`IRQ_BITS-1:0]  irq_clear;
  logic                  apb_setup;
  logic                  apb_commit;
  logic                  addr_hit;
  logic [31:0]           read_word;
  logic [15:0]           lookup_word;
  logic                  lookup_valid;
  logic                  restart;

  // Unit number from the two decimal digits
  always_comb
  begin
    // Widen before the product, a 4-bit product would wrap above 15
    unit_raw = 7'(unit_tens_sw) * 7'h0a + 7'(unit_ones_sw);
    unit_bad = (unit_tens_sw > `DIGIT_MAX) || (unit_ones_sw > `DIGIT_MAX)
               || (unit_raw > (node_range_sw ? `UNIT_MAX_WIDE : `UNIT_MAX_NARROW));
  end

  // Host claims, checked against captured settings
  always_comb
  begin
    claim_hit = 1'b0;
    if (!st_reg.bad_setting)
    begin
      claim_hit = host_unit_claimed[st_reg.unit];
      if (st_reg.node_wide)
        claim_hit = claim_hit || host_unit_claimed[st_reg.unit + 7'h01];
    end
  end

  // Word window and timing derived from the captured settings
  always_comb
  begin
    first_word  = `IO_BASE_WORD + 16'(st_reg.unit) * `IO_UNIT_STRIDE;
    param_word  = `PARAM_BASE_WORD + 16'(st_reg.unit) * `PARAM_STRIDE;
    data_words  = st_reg.node_wide ? `DATA_WORDS_WIDE : `DATA_WORDS_NAR;
    stat_words  = st_reg.node_wide ? `STAT_WORDS_WIDE : `STAT_WORDS_NAR;
    total_words = st_reg.node_wide ? `TOTAL_WORDS_WID : `TOTAL_WORDS_NAR;
    baud_bps    = st_reg.rate_long ? `BAUD_LONG_BPS : `BAUD_FAST_BPS;
    case ({st_reg.rate_long, st_reg.node_wide})
      2'b00:   cyc_len = 23'(CYC_FAST_NAR);
      2'b01:   cyc_len = 23'(CYC_FAST_WID);
      2'b10:   cyc_len = 23'(CYC_LONG_NAR);
      default: cyc_len = 23'(CYC_LONG_WID);
    endcase
    node_mask   = st_reg.node_wide ? 16'hffff : 16'h00ff;
  end

  // Slave presence, inputs and outputs kept apart
  always_comb
  begin
    present_now = {slave_out_present & node_mask, slave_in_present & node_mask};
    joined      = present_now & ~st_reg.present;
  end

  // Node lookup: outputs first, inputs next, two slaves a word
  always_comb
  begin
    lookup_word  = first_word + 16'(st_reg.lookup[3:1]);
    if (st_reg.lookup[4])
      lookup_word = lookup_word + 16'(data_words);
    lookup_valid = (st_reg.lookup[3] == 1'b0) || st_reg.node_wide;
  end

  // APB decode; the write lands on the edge where pready is seen high
  always_comb
  begin
    apb_setup  = psel && penable && !st_reg.pready;
    apb_commit = psel && penable && st_reg.pready;
    addr_hit   = 1'b1;
    read_word  = 32'h0000_0000;
    case (paddr)
      `OFS_CONFIG:     read_word = {20'h00000, st_reg.regs_en, st_reg.stop_mode,
                                    st_reg.rate_long, st_reg.node_wide, 1'b0, st_reg.unit};
      `OFS_IO_BASE:    read_word = {stat_words, total_words, first_word};
      `OFS_PARAM_BASE: read_word = {`PARAM_SIZE, param_word};
      `OFS_BAUD:       read_word = {12'h000, baud_bps};
      `OFS_CYCLE:      read_word = {9'h000, cyc_len};
      `OFS_STATUS:     read_word = {23'h000000, st_reg.link_ok, st_reg.exchange_en,
                                    st_reg.bad_setting, st_reg.dup_fault, st_reg.state};
      `OFS_CONTROL:    read_word = 32'h0000_0000;
      `OFS_IRQ_STAT:   read_word = {26'h0000000, st_reg.irq_stat};
      `OFS_IRQ_MASK:   read_word = {26'h0000000, st_reg.irq_mask};
      `OFS_REG_TABLE:  read_word = st_reg.reg_table;
      `OFS_PRESENT:    read_word = st_reg.present;
      `OFS_LOOKUP:     read_word = {14'h0000, lookup_valid, st_reg.lookup[0], lookup_word};
      default:         addr_hit  = 1'b0;
    endcase
    restart   = apb_commit && pwrite && (paddr == `OFS_CONTROL) && pwdata[0];
    irq_clear = '0;
    if (apb_commit && pwrite && (paddr == `OFS_IRQ_STAT))
      irq_clear = pwdata[`IRQ_BITS-1:0];
  end

  // Next state of the whole block
  always_comb
  begin
    st_next              = st_reg;
    irq_event            = '0;
    st_next.cycle_strobe = 1'b0;

    case (st_reg.state)
      ST_LOAD:
      begin
        // Only place the switches are looked at
        st_next.unit        = unit_raw;
        st_next.node_wide   = node_range_sw;
        st_next.rate_long   = bus_rate_select;
        st_next.stop_mode   = stop_on_error_sw;
        st_next.regs_en     = registration_sw;
        st_next.bad_setting = unit_bad;
        st_next.dup_fault   = 1'b0;
        st_next.cyc_cnt     = '0;
        st_next.state       = ST_CHECK;
      end
      ST_CHECK:
      begin
        if (st_reg.bad_setting)
        begin
          irq_event[`IRQ_BAD_SETTING] = 1'b1;
          st_next.state               = ST_FAULT;
        end
        else if (claim_hit)
        begin
          st_next.dup_fault        = 1'b1;
          irq_event[`IRQ_DUP_UNIT] = 1'b1;
          st_next.state            = ST_FAULT;
        end
        else
        begin
          st_next.exchange_en = 1'b1;
          st_next.state       = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (st_reg.cyc_cnt >= cyc_len - 23'h000001)
        begin
          st_next.cyc_cnt      = '0;
          st_next.cycle_strobe = 1'b1;
        end
        else
          st_next.cyc_cnt = st_reg.cyc_cnt + 23'h000001;
        if (link_ok_lamp_error)
        begin
          irq_event[`IRQ_LINK_OK_LAMP_ERR] = 1'b1;
          if (st_reg.stop_mode)
          begin
            irq_event[`IRQ_HALT] = 1'b1;
            st_next.exchange_en  = 1'b0;
            st_next.cycle_strobe = 1'b0;
            st_next.state        = ST_HALT;
          end
        end
      end
      ST_HALT:
        st_next.exchange_en = 1'b0;
      ST_FAULT:
        st_next.exchange_en = 1'b0;
      default:
        st_next.state = ST_LOAD;
    endcase

    // Mismatched slaves only drop out of presence; the lamp follows the master
    st_next.link_ok = (st_next.state == ST_RUN) && !link_ok_lamp_error;

    // Presence tracking and registration check
    if (st_reg.state == ST_RUN)
    begin
      st_next.present = present_now;
      if (st_reg.regs_en)
      begin
        irq_event[`IRQ_UNREG_JOIN] = |(joined & ~st_reg.reg_table);
        irq_event[`IRQ_REG_JOIN]   = |(joined & st_reg.reg_table);
      end
    end
    else
      st_next.present = '0;

    if (restart)
    begin
      // Restart ends any halt or fault and reloads the switches
      st_next.state       = ST_LOAD;
      st_next.exchange_en = 1'b0;
      st_next.link_ok     = 1'b0;
    end

    // APB writes
    if (apb_commit && pwrite)
    begin
      case (paddr)
        `OFS_IRQ_MASK:  st_next.irq_mask  = pwdata[`IRQ_BITS-1:0];
        `OFS_REG_TABLE: st_next.reg_table = pwdata;
        `OFS_LOOKUP:    st_next.lookup    = pwdata[4:0];
        default:        st_next.lookup    = st_reg.lookup;
      endcase
    end

    // Set wins over a clear in the same cycle
    st_next.irq_stat = (st_reg.irq_stat & ~irq_clear) | irq_event;
    st_next.irq      = |(st_next.irq_stat & st_next.irq_mask);

    // One wait state: data latched in the first access cycle
    st_next.pready  = apb_setup;
    st_next.pslverr = apb_setup && !addr_hit;
    st_next.prdata  = (apb_setup && !pwrite) ? read_word : 32'h0000_0000;
  end

  // Reset leaves switches read as off and unit 00
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg       <= '0;
      st_reg.state <= ST_LOAD;
    end
    else
      st_reg <= st_next;
  end

  assign pready          = st_reg.pready;
  assign prdata          = st_reg.prdata;
  assign pslverr         = st_reg.pslverr;
  assign exchange_enable = st_reg.exchange_en;
  assign cycle_strobe    = st_reg.cycle_strobe;
  assign link_ok_lamp    = st_reg.link_ok;
  assign irq             = st_reg.irq;

endmodule : fieldbus_master_setup_decode

// ---- bench/setup_decode_monitor.sv ----
/*
  Port assertions for the fieldbus setup decoder.
  Assumes one pclk domain, presetn asynchronous and active low.
*/
`timescale 1ns/1ps
module setup_decode_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        stop_on_error_sw,
  input wire logic        link_ok_lamp_error,
  input wire logic        exchange_enable,
  input wire logic        cycle_strobe,
  input wire logic        link_ok_lamp
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_access;
    psel && penable && !$past(penable);
  endsequence
  sequence s_answer;
    !pready ##1 pready;
  endsequence

  AST_APB_WAIT: assert property (s_access |-> s_answer)
    else $error("pready not in second access cycle");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_SLVERR_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_PRDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  AST_LAMP_ERR: assert property (link_ok_lamp_error |=> !link_ok_lamp)
    else $error("lamp lit after line error");
  AST_LAMP_RUN: assert property (link_ok_lamp |-> exchange_enable)
    else $error("lamp lit outside exchange");
  AST_STROBE_GAP: assert property (cycle_strobe |=> !cycle_strobe [*3])
    else $error("bus cycle strobes too close");
  AST_STOP_HALT: assert property (exchange_enable && link_ok_lamp_error && stop_on_error_sw
    |=> !exchange_enable)
    else $error("no halt on error in stop mode");
  AST_NO_STOP: assert property (exchange_enable && link_ok_lamp_error && !stop_on_error_sw
    && !psel |=> exchange_enable)
    else $error("exchange dropped in continue mode");
endmodule : setup_decode_monitor

bind fieldbus_master_setup_decode setup_decode_monitor u_setup_decode_monitor (.*);

// ---- bench/slave_bus_model.sv ----
/*
  Remote slave model: presence per node and line errors.
  Assumes requests change just after rising pclk.
*/
`timescale 1ns/1ps
module slave_bus_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [15:0] join_in,
  input  wire logic [15:0] join_out,
  input  wire logic [15:0] rate_bad,
  input  wire logic        line_fault,
  output logic      [15:0] slave_in_present,
  output logic      [15:0] slave_out_present,
  output logic             link_ok_lamp_error
);
  // Wrong-rate slave stays silent, the rest carry on
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      slave_in_present  <= 16'h0000;
      slave_out_present <= 16'h0000;
      link_ok_lamp_error        <= 1'b0;
    end
    else
    begin
      slave_in_present  <= join_in & ~rate_bad;
      slave_out_present <= join_out & ~rate_bad;
      link_ok_lamp_error        <= line_fault;
    end
endmodule : slave_bus_model

// ---- bench/fieldbus_master_setup_decode_tb.sv ----
/*
  Self-checking bench for the fieldbus setup decoder.
  Assumes the slave model and the bound monitor are compiled alongside.
*/
`timescale 1ns/1ps
module fieldbus_master_setup_decode_tb;
  typedef struct {int n; logic w; logic r; logic [31:0] cyc;} row_t;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  unit_tens_sw, unit_ones_sw;
  logic        node_range_sw, bus_rate_select, stop_on_error_sw, registration_sw;
  logic [95:0] host_unit_claimed;
  logic [15:0] slave_in_present, slave_out_present, join_in, join_out, rate_bad;
  logic        link_ok_lamp_error, line_fault, exchange_enable, cycle_strobe, link_ok_lamp, irq;
  int          err_count = 0;
  int          checked = 0;
  row_t        rows[4] = '{'{0, 0, 0, 4}, '{95, 0, 1, 8}, '{94, 1, 0, 6}, '{37, 1, 1, 10}};

  // Short bus cycles keep the run brief
  fieldbus_master_setup_decode #(.CYC_FAST_NAR(4), .CYC_FAST_WID(6), .CYC_LONG_NAR(8),
    .CYC_LONG_WID(10)) u_fieldbus_master_setup_decode (.*);
  slave_bus_model u_slave_bus_model (.*);

  always #12.5 pclk = ~pclk;

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 40);
    if (k == 40)
      chk("pready", 1'b0, 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask : rchk

  task sw(input int n, input logic w, r, s, g);
    unit_tens_sw     <= 4'(n / 10);
    unit_ones_sw     <= 4'(n % 10);
    node_range_sw    <= w;
    bus_rate_select  <= r;
    stop_on_error_sw <= s;
    registration_sw  <= g;
  endtask : sw

  // Clear sticky flags first, so each case sees only its own events
  task restart();
    apb(1'b1, 8'h1c, 32'h3f);
    apb(1'b1, 8'h18, 32'h1);
    repeat (6) @(posedge pclk);
  endtask : restart

  task pulse();
    line_fault <= 1'b1;
    @(posedge pclk);
    line_fault <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : pulse

  task lk(input logic [4:0] q, input logic [31:0] exp);
    apb(1'b1, 8'h2c, {27'h0, q});
    rchk(8'h2c, exp, "lookup");
  endtask : lk

  task results();
    if (err_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  initial
  begin
    logic [31:0] f;
    int          n;
    {presetn, psel, penable, pwrite, paddr, pwdata, line_fault} = '0;
    {join_in, join_out, rate_bad, host_unit_claimed} = '0;
    {unit_tens_sw, unit_ones_sw, node_range_sw, bus_rate_select} = '0;
    {stop_on_error_sw, registration_sw} = '0;
    repeat (16) @(posedge pclk);
    chk("exch_reset", exchange_enable, 1'b0);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    rchk(8'h00, 32'h0, "config");
    rchk(8'h14, 32'h184, "status");
    foreach (rows[i])
    begin
      sw(rows[i].n, rows[i].w, rows[i].r, 1'b0, 1'b0);
      restart();
      f = 16'h07d0 + 16'h000a * rows[i].n;
      rchk(8'h00, {22'h0, rows[i].r, rows[i].w, 1'b0, 7'(rows[i].n)}, "config");
      rchk(8'h04, {rows[i].w ? 16'h0414 : 16'h020a, f[15:0]}, "io");
      f = 16'h4e20 + 16'h0064 * rows[i].n;
      rchk(8'h08, {16'h0064, f[15:0]}, "param");
      rchk(8'h0c, rows[i].r ? 32'h00016e36 : 32'h000b71b0, "baud");
      rchk(8'h10, rows[i].cyc, "cycle");
    end
    apb(1'b0, 8'h30, 32'h0);
    chk("slverr", er, 1'b1);
    sw(96, 0, 0, 0, 0);
    restart();
    chk("exch_bad", exchange_enable, 1'b0);
    rchk(8'h1c, 32'h08, "irq_bad");
    sw(95, 1, 0, 0, 0);
    restart();
    chk("exch_bad_wide", exchange_enable, 1'b0);
    host_unit_claimed[11] <= 1'b1;
    sw(10, 1, 0, 0, 0);
    restart();
    rchk(8'h1c, 32'h04, "irq_dup");
    sw(10, 0, 0, 0, 0);
    restart();
    chk("exch_free", exchange_enable, 1'b1);
    apb(1'b1, 8'h20, 32'h1);
    pulse();
    chk("exch_cont", exchange_enable, 1'b1);
    chk("irq_set", irq, 1'b1);
    apb(1'b1, 8'h1c, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq_clear", irq, 1'b0);
    sw(0, 0, 0, 1, 0);
    restart();
    pulse();
    chk("exch_halt", exchange_enable, 1'b0);
    repeat (20) @(posedge pclk);
    rchk(8'h14, 32'h08, "status_halt");
    restart();
    chk("exch_again", exchange_enable, 1'b1);
    sw(55, 1, 1, 0, 1);
    repeat (4) @(posedge pclk);
    rchk(8'h00, 32'h400, "config_held");
    sw(0, 0, 0, 0, 1);
    restart();
    apb(1'b1, 8'h24, 32'h1);
    rate_bad <= 16'h0002;
    join_in  <= 16'h0103;
    join_out <= 16'h0001;
    repeat (4) @(posedge pclk);
    rchk(8'h1c, 32'h30, "irq_join");
    rchk(8'h28, 32'h00010001, "present");
    chk("lamp", link_ok_lamp, 1'b1);
    // Narrow fast bus cycle is 4 clocks here, so 40 edges hold 10 strobes
    n = 0;
    repeat (40)
    begin
      @(posedge pclk);
      n += int'(cycle_strobe === 1'b1);
    end
    chk("strobes", 32'(n), 32'd10);
    lk(5'h03, 32'h000307d1);
    lk(5'h13, 32'h000307d5);
    lk(5'h12, 32'h000207d5);
    sw(0, 1, 0, 0, 0);
    restart();
    lk(5'h19, 32'h000307dc);
    results();
  end

  initial
  begin
    #200000;
    err_count++;
    results();
  end
endmodule : fieldbus_master_setup_decode_tb
